// ==== ecl_img_mem.sv ====
`default_nettype none
module ecl_img_mem
    import ecl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [3:0] raddr,
    output logic [15:0] rdata
);
    typedef struct packed {
        logic [15:0][15:0] mem;
        logic [15:0] rd;
    } ecl_mem_s;

    ecl_mem_s q, d;

    always_comb begin
        d = q;
        if (we) begin
            d.mem[waddr] = wdata;
        end
        d.rd = q.mem[raddr];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rd;
endmodule
`default_nettype wire

// ==== ecl_loader.sv ====
// Our own choices: the APB register port and the placing of the registers.
`default_nettype none
module ecl_loader
    import ecl_pkg::*;
#(
    parameter logic [15:0] ACK_TMO_CYC = ECL_ACK_TMO_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic [7:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_word,
    output logic load_done
);
    typedef struct packed {
        ecl_ld_e st;
        logic [3:0] slot;
        logic [15:0] tmo;
        logic start_pend;
        logic done;
        logic err;
        logic [3:0] nloaded;
        logic mem_req;
        logic [7:0] mem_addr;
        logic acc;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        ecl_ports_t port;
    } ecl_ld_s;

    ecl_ld_s q, d;

    logic ack_s;
    logic img_we;
    logic [15:0] img_rdata;
    logic busy;
    logic sel_ctl;
    logic sel_stat;
    logic sel_img;
    logic sel_cfg;
    logic need_wait;
    logic wr_done;
    logic [2:0] pidx;
    logic [32:0] cfg_rd;
    logic [31:0] stat_val;

    // word address of each load slot
    function automatic logic [7:0] slot_addr(input logic [3:0] s);
        logic [7:0] a;
        case (s)
            4'h0: a = ECL_W_P5_PHY2_HI;
            4'h1: a = ECL_W_P4_PHY;
            4'h2: a = ECL_W_P5_PHY;
            default: a = ECL_W_PM_BASE + 8'(s - 4'h3);
        endcase
        return a;
    endfunction

    // scatter one loaded word into the port fields
    function automatic ecl_ports_t scatter(input ecl_ports_t pin, input logic [7:0] a, input logic [15:0] w);
        ecl_ports_t p;
        p = pin;
        if (a == ECL_W_P5_PHY2_HI) begin
            p[5].phy2_hi = w[ECL_S_PHY2_HI +: 15];
        end
        if (a == ECL_W_P4_PHY) begin
            p[4].deemph = w[ECL_S_DEEMPH];
            p[4].cmp_det = w[ECL_S_CMP_DET];
            p[4].data_change_count_select = w[ECL_S_DCHG_SEL +: 2];
        end
        if (a == ECL_W_P5_PHY) begin
            p[5].phy2_lo = w[ECL_S_PHY2_LO +: 5];
            p[5].phy3 = w[ECL_S_PHY3 +: 7];
            p[5].deemph = w[ECL_S_DEEMPH];
            p[5].cmp_det = w[ECL_S_CMP_DET];
            p[5].data_change_count_select = w[ECL_S_DCHG_SEL +: 2];
        end
        // ports 0 to 3 share one layout, two words per port
        for (int i = 0; i < 4; i++) begin
            if (a == ECL_W_PM_BASE + 8'(2 * i)) begin
                p[i].no_soft_rst = w[ECL_S_NO_SOFT_RST];
                p[i].aux_cur = w[ECL_S_AUX_CUR +: 3];
                p[i].d1_sup = w[ECL_S_D1_SUP];
                p[i].d2_sup = w[ECL_S_D2_SUP];
                p[i].pme_sup = w[ECL_S_PME_SUP +: 2];
            end
            if (a == ECL_W_PM_BASE + 8'(2 * i + 1)) begin
                p[i].pm_data = w[ECL_S_PM_DATA +: 8];
            end
        end
        return p;
    endfunction

    // compose one configuration register of a port, top bit is the hit flag
    function automatic logic [32:0] cfg_read(input ecl_port_s f, input logic [7:0] off);
        logic [31:0] v;
        logic hit;
        v = '0;
        hit = 1'b1;
        case (off)
            ECL_CFG_PM_CAP: begin
                v[ECL_F_AUX_CUR +: 3] = f.aux_cur;
                v[ECL_F_D1_SUP] = f.d1_sup;
                v[ECL_F_D2_SUP] = f.d2_sup;
                v[ECL_F_PME_SUP +: 2] = f.pme_sup;
            end
            ECL_CFG_PM_CSR: begin
                v[ECL_F_NO_SOFT_RST] = f.no_soft_rst;
                v[ECL_F_PM_DATA +: 8] = f.pm_data;
            end
            ECL_CFG_LINK: begin
                v[ECL_F_CMP_DET] = f.cmp_det;
            end
            ECL_CFG_PHY2: begin
                v[ECL_F_PHY2_HI +: 15] = f.phy2_hi;
                v[ECL_F_PHY2_LO +: 5] = f.phy2_lo;
            end
            ECL_CFG_TL: begin
                v[ECL_F_DCHG_SEL +: 2] = f.data_change_count_select;
            end
            ECL_CFG_PHY3: begin
                v[ECL_F_PHY3 +: 7] = f.phy3;
            end
            ECL_CFG_DEEMPH: begin
                v[ECL_F_DEEMPH] = f.deemph;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return {hit, v};
    endfunction

    // memory acknowledge comes from outside the clock domain
    ecl_sync u_ack_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(mem_ack),
        .sync_out(ack_s)
    );

    // image of the raw loaded words, readable over apb
    ecl_img_mem u_img (
        .pclk(pclk),
        .presetn(presetn),
        .we(img_we),
        .waddr(q.slot),
        .wdata(mem_word),
        .raddr(paddr[5:2]),
        .rdata(img_rdata)
    );

    assign img_we = (q.st == LD_REQ) && ack_s;

    // address decode
    always_comb begin
        busy = (q.st != LD_IDLE) || q.start_pend;
        sel_ctl = (paddr == ECL_APB_CTRL);
        sel_stat = (paddr == ECL_APB_STAT);
        sel_img = (paddr[11:10] == ECL_APB_IMG_TOP) && (paddr[9:6] == 4'h0) && (paddr[1:0] == 2'h0)
            && (paddr[5:2] < 4'(ECL_NSLOT));
        pidx = paddr[10:8];
        cfg_rd = '0;
        if (!paddr[11] && (pidx < 3'(ECL_NPORT)) && (paddr[1:0] == 2'h0)) begin
            cfg_rd = cfg_read(q.port[pidx], paddr[7:0]);
        end
        sel_cfg = cfg_rd[32];
        need_wait = (sel_cfg || sel_img) && busy;
        wr_done = psel && penable && q.pready && pwrite;
        stat_val = '0;
        stat_val[ECL_STAT_BUSY] = busy;
        stat_val[ECL_STAT_DONE] = q.done;
        stat_val[ECL_STAT_ERR] = q.err;
        stat_val[ECL_STAT_NLOAD +: 4] = q.nloaded;
    end

    always_comb begin
        d = q;

        // apb slave: one wait state, longer while loading blocks a config or image access
        d.pready = 1'b0;
        d.acc = psel && !q.pready && !q.acc && !need_wait;
        if (q.acc && psel) begin
            d.pready = 1'b1;
            d.pslverr = !(sel_ctl || sel_stat || sel_img || sel_cfg);
            d.prdata = '0;
            if (!pwrite) begin
                if (sel_stat) begin
                    d.prdata = stat_val;
                end else if (sel_img) begin
                    d.prdata = {16'h0000, img_rdata};
                end else if (sel_cfg) begin
                    d.prdata = cfg_rd[31:0];
                end
            end
        end else begin
            // answer stands for one cycle only
            d.pslverr = 1'b0;
            d.prdata = '0;
        end

        // reload request, ignored while a load runs
        if (wr_done && sel_ctl && pwdata[ECL_CTRL_RELOAD] && !busy) begin
            d.start_pend = 1'b1;
        end

        // loader sequence
        case (q.st)
            LD_IDLE: begin
                if (q.start_pend) begin
                    d.start_pend = 1'b0;
                    d.done = 1'b0;
                    d.err = 1'b0;
                    d.nloaded = 4'h0;
                    d.slot = 4'h0;
                    d.tmo = 16'h0000;
                    d.port = {ECL_NPORT{ECL_PORT_RST}};
                    d.mem_req = 1'b1;
                    d.mem_addr = slot_addr(4'h0);
                    d.st = LD_REQ;
                end
            end
            LD_REQ: begin
                d.tmo = q.tmo + 16'h0001;
                if (ack_s) begin
                    d.port = scatter(q.port, q.mem_addr, mem_word);
                    d.nloaded = q.nloaded + 4'h1;
                    d.mem_req = 1'b0;
                    d.tmo = 16'h0000;
                    d.st = LD_REL;
                end else if (q.tmo == ACK_TMO_CYC - 16'h0001) begin
                    d.mem_req = 1'b0;
                    d.err = 1'b1;
                    d.st = LD_IDLE;
                end
            end
            LD_REL: begin
                d.tmo = q.tmo + 16'h0001;
                if (!ack_s) begin
                    d.tmo = 16'h0000;
                    if (q.slot == 4'(ECL_NSLOT - 1)) begin
                        d.done = 1'b1;
                        d.st = LD_IDLE;
                    end else begin
                        d.slot = q.slot + 4'h1;
                        d.mem_addr = slot_addr(q.slot + 4'h1);
                        d.mem_req = 1'b1;
                        d.st = LD_REQ;
                    end
                end else if (q.tmo == ACK_TMO_CYC - 16'h0001) begin
                    d.err = 1'b1;
                    d.st = LD_IDLE;
                end
            end
            default: begin
                d.mem_req = 1'b0;
                d.st = LD_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.st <= LD_IDLE;
            q.start_pend <= 1'b1;
            q.port <= {ECL_NPORT{ECL_PORT_RST}};
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign mem_req = q.mem_req;
    assign mem_addr = q.mem_addr;
    assign load_done = q.done;
endmodule
`default_nettype wire

// ==== ecl_loader_sva.sv ====
`default_nettype none
module ecl_loader_chk #(
    parameter logic [15:0] ACK_TMO_CYC = 16'd40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic [7:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_word,
    input wire logic load_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic prev_q;
    logic [7:0] last_q;
    logic [15:0] wait_q;
    function automatic logic [7:0] nxt(input logic [7:0] a);
        case (a)
            8'h3A: return 8'h48;
            8'h48: return 8'h4A;
            8'h4A: return 8'h50;
            default: return a + 8'h01;
        endcase
    endfunction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
            last_q <= 8'h00;
            wait_q <= 16'h0000;
        end else begin
            prev_q <= mem_req;
            if (mem_req && !prev_q) last_q <= mem_addr;
            wait_q <= (mem_req && !mem_ack) ? wait_q + 16'h0001 : 16'h0000;
        end
    end
    AST_FIRST_WORD: assert property ($rose(presetn) |-> ##[0:2] (mem_req && mem_addr == 8'h3A))
        else $error("first request not word 3A");
    AST_WORD_ORDER: assert property (mem_req && !prev_q && last_q != 8'h00 |->
        mem_addr == 8'h3A || mem_addr == nxt(last_q))
        else $error("word order broken");
    AST_ADDR_STABLE: assert property (mem_req && $past(mem_req) |-> $stable(mem_addr))
        else $error("address moved during request");
    AST_ACK_RESPONSE: assert property ($rose(mem_ack) && mem_req |=> mem_req [*2] ##[1:5] !mem_req)
        else $error("request not released after ack");
    AST_REQ_HOLD: assert property (mem_req && !mem_ack && wait_q < ACK_TMO_CYC / 2 |=> mem_req)
        else $error("request dropped without ack");
    AST_TMO_BOUND: assert property (mem_req |-> wait_q <= ACK_TMO_CYC + 16'd4)
        else $error("ack timeout not taken");
    AST_DONE_LAST: assert property ($rose(load_done) |-> last_q == 8'h57)
        else $error("done before last word");
    AST_DONE_IDLE: assert property (mem_req |-> !load_done)
        else $error("done while loading");
    AST_CFG_STALL: assert property (pready && !paddr[11] |-> !mem_req && psel && penable)
        else $error("config answered during load");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0 ##1 prdata == 32'h0)
        else $error("error answer carries data");
endmodule
bind ecl_loader ecl_loader_chk #(.ACK_TMO_CYC(ACK_TMO_CYC)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_word(mem_word), .load_done(load_done));
`default_nettype wire

// ==== ecl_mem_model.sv ====
`default_nettype none
module ecl_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic [7:0] mem_addr,
    input wire logic [15:0] salt,
    input wire logic mute,
    input wire logic [3:0] lag,
    output logic mem_ack,
    output logic [15:0] mem_word
);
    logic [3:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_word <= 16'h0000;
            cnt_q <= 4'h0;
        end else if (mem_req && !mem_ack && !mute) begin
            cnt_q <= cnt_q + 4'h1;
            // word is set up one cycle before the ack rises
            if (cnt_q == lag) mem_word <= {mem_addr, mem_addr} ^ salt;
            if (cnt_q > lag) mem_ack <= 1'b1;
        end else if (!mem_req) begin
            cnt_q <= 4'h0;
            mem_ack <= 1'b0;
            // released bus shows garbage
            if (mem_ack) mem_word <= ~mem_word;
        end
    end
endmodule
`default_nettype wire

// ==== ecl_pkg.sv ====
`default_nettype none
package ecl_pkg;
    localparam int ECL_NPORT = 6;
    localparam int ECL_NSLOT = 11;
    localparam int ECL_CLK_MHZ = 200;

    // word addresses in the configuration memory
    localparam logic [7:0] ECL_W_P5_PHY2_HI = 8'h3A;
    localparam logic [7:0] ECL_W_P4_PHY = 8'h48;
    localparam logic [7:0] ECL_W_P5_PHY = 8'h4A;
    localparam logic [7:0] ECL_W_PM_BASE = 8'h50;

    // configuration register offsets inside one port
    localparam logic [7:0] ECL_CFG_PM_CAP = 8'h40;
    localparam logic [7:0] ECL_CFG_PM_CSR = 8'h44;
    localparam logic [7:0] ECL_CFG_LINK = 8'h78;
    localparam logic [7:0] ECL_CFG_PHY2 = 8'h7C;
    localparam logic [7:0] ECL_CFG_TL = 8'h8C;
    localparam logic [7:0] ECL_CFG_PHY3 = 8'h90;
    localparam logic [7:0] ECL_CFG_DEEMPH = 8'hF0;

    // field positions in the configuration registers
    localparam int ECL_F_PHY2_HI = 16;
    localparam int ECL_F_PHY2_LO = 8;
    localparam int ECL_F_PHY3 = 0;
    localparam int ECL_F_DEEMPH = 6;
    localparam int ECL_F_CMP_DET = 11;
    localparam int ECL_F_DCHG_SEL = 8;
    localparam int ECL_F_NO_SOFT_RST = 3;
    localparam int ECL_F_PM_DATA = 24;
    localparam int ECL_F_AUX_CUR = 22;
    localparam int ECL_F_D1_SUP = 25;
    localparam int ECL_F_D2_SUP = 26;
    localparam int ECL_F_PME_SUP = 28;

    // field positions in the loaded words
    localparam int ECL_S_PHY2_HI = 0;
    localparam int ECL_S_PHY2_LO = 0;
    localparam int ECL_S_PHY3 = 5;
    localparam int ECL_S_DEEMPH = 12;
    localparam int ECL_S_CMP_DET = 13;
    localparam int ECL_S_DCHG_SEL = 14;
    localparam int ECL_S_NO_SOFT_RST = 0;
    localparam int ECL_S_AUX_CUR = 1;
    localparam int ECL_S_D1_SUP = 4;
    localparam int ECL_S_D2_SUP = 5;
    localparam int ECL_S_PME_SUP = 6;
    localparam int ECL_S_PM_DATA = 8;

    // apb map
    localparam logic [11:0] ECL_APB_CTRL = 12'h800;
    localparam logic [11:0] ECL_APB_STAT = 12'h804;
    localparam logic [1:0] ECL_APB_IMG_TOP = 2'h3;
    localparam int ECL_CTRL_RELOAD = 0;
    localparam int ECL_STAT_BUSY = 0;
    localparam int ECL_STAT_DONE = 1;
    localparam int ECL_STAT_ERR = 2;
    localparam int ECL_STAT_NLOAD = 8;

    // memory handshake timeout
    localparam int ECL_ACK_TMO_NS = 100000;
    localparam logic [15:0] ECL_ACK_TMO_CYC = 16'((ECL_ACK_TMO_NS * ECL_CLK_MHZ) / 1000);

    typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_REL} ecl_ld_e;

    typedef struct packed {
        logic [14:0] phy2_hi;
        logic [4:0] phy2_lo;
        logic [6:0] phy3;
        logic deemph;
        logic cmp_det;
        logic [1:0] data_change_count_select;
        logic no_soft_rst;
        logic [2:0] aux_cur;
        logic d1_sup;
        logic d2_sup;
        logic [1:0] pme_sup;
        logic [7:0] pm_data;
    } ecl_port_s;

    typedef ecl_port_s [ECL_NPORT-1:0] ecl_ports_t;

    localparam ecl_port_s ECL_PORT_RST = '0;
    localparam logic [15:0] ECL_WORD_RST = 16'h0000;
endpackage
`default_nettype wire

// ==== ecl_sync.sv ====
`default_nettype none
module ecl_sync
    import ecl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic o;
    } ecl_sync_s;

    ecl_sync_s q, d;

    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a change counts once the second and third stages agree
        if (q.s2 == q.s3) begin
            d.o = q.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.o;
endmodule
`default_nettype wire

// ==== testbench.sv ====
`default_nettype none
`define ECL_CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ecl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mem_req;
    logic [7:0] mem_addr;
    logic mem_ack;
    logic [15:0] mem_word;
    logic load_done;
    logic [15:0] salt = 16'hA5C3;
    logic mute = 1'b0;
    logic [3:0] lag = 4'h0;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    ecl_loader #(.ACK_TMO_CYC(16'd40)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_word(mem_word), .load_done(load_done));
    ecl_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr), .salt(salt),
        .mute(mute), .lag(lag), .mem_ack(mem_ack), .mem_word(mem_word));
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run;
        end
    end
    function automatic logic [15:0] wv(input logic [7:0] a);
        return {a, a} ^ salt;
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `ECL_CHK($sformatf("reg %h", a), exp, rd)
    endtask
    task automatic t_status(input logic [31:0] exp);
        for (int i = 0; i < 3000 && load_done !== 1'b1; i++) @(posedge pclk);
        `ECL_CHK("load_done", 1'b1, load_done)
        rd_chk(ECL_APB_STAT, exp);
        $display("test status done");
    endtask
    task automatic t_phy;
        logic [15:0] h;
        logic [15:0] g;
        logic [15:0] w;
        h = wv(8'h3A);
        g = wv(8'h48);
        w = wv(8'h4A);
        rd_chk(12'h57C, {1'b0, h[14:0], 3'b000, w[4:0], 8'h00});
        rd_chk(12'h590, {25'h0, w[11:5]});
        rd_chk(12'h5F0, 32'(w[12]) << 6);
        rd_chk(12'h578, 32'(w[13]) << 11);
        rd_chk(12'h58C, 32'(w[15:14]) << 8);
        rd_chk(12'h478, 32'(g[13]) << 11);
        rd_chk(12'h48C, 32'(g[15:14]) << 8);
        rd_chk(12'h47C, 32'h0);
        rd_chk(12'hC00, {16'h0000, h});
        rd_chk(12'hC28, {16'h0000, wv(8'h57)});
        $display("test phy done");
    endtask
    task automatic t_pm;
        logic [15:0] c;
        logic [15:0] d;
        for (int p = 0; p < 4; p++) begin
            c = wv(8'h50 + 8'(2 * p));
            d = wv(8'h51 + 8'(2 * p));
            rd_chk(12'(p * 256 + 64), {2'b00, c[7:6], 1'b0, c[5], c[4], c[3:1], 22'h0});
            rd_chk(12'(p * 256 + 68), {d[15:8], 20'h0, c[0], 3'b000});
        end
        $display("test pm done");
    endtask
    task automatic t_refuse;
        logic [31:0] v;
        apb(1'b0, 12'h504, 32'h0);
        `ECL_CHK("unmapped err", 1'b1, er)
        `ECL_CHK("unmapped data", 32'h0, rd)
        apb(1'b0, 12'h044, 32'h0);
        v = rd;
        apb(1'b1, 12'h044, 32'hFFFF_FFFF);
        rd_chk(12'h044, v);
        $display("test refuse done");
    endtask
    task automatic t_reload;
        logic [15:0] e;
        logic [15:0] f;
        salt <= 16'h5A3C;
        lag <= 4'h5;
        apb(1'b1, ECL_APB_CTRL, 32'h1);
        e = wv(8'h57);
        f = wv(8'h56);
        // read issued mid-load must stall until all words are in
        rd_chk(12'h344, {e[15:8], 20'h0, f[0], 3'b000});
        t_status(32'h0000_0B02);
        t_phy;
        t_pm;
        $display("test reload done");
    endtask
    task automatic t_timeout;
        mute <= 1'b1;
        apb(1'b1, ECL_APB_CTRL, 32'h1);
        for (int i = 0; i < 20 && mem_req !== 1'b1; i++) @(posedge pclk);
        for (int i = 0; i < 200 && mem_req !== 1'b0; i++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        rd_chk(ECL_APB_STAT, 32'h0000_0004);
        `ECL_CHK("done after abort", 1'b0, load_done)
        rd_chk(12'h044, 32'h0);
        mute <= 1'b0;
        apb(1'b1, ECL_APB_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        t_status(32'h0000_0B02);
        $display("test timeout done");
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_status(32'h0000_0B02);
        t_phy;
        t_pm;
        t_refuse;
        t_reload;
        t_timeout;
        complete_run;
    end
endmodule
`default_nettype wire
